// ===== logic/spf_defs.svh
// Purpose: Constants of the supply-pulse fuse programmer
// Assumes: Included by spf_pkg and by the design modules
// Notes:   Definitions only
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

// -----------------------------------------------------------------
// Field widths
// -----------------------------------------------------------------
`define SPF_OP_W         6
`define SPF_HYS_W        2
`define SPF_ADDR_W       8
`define SPF_FUSE_N       10
`define SPF_IDX_W        4
`define SPF_CNT_W        4

// -----------------------------------------------------------------
// Fuse vector positions
// -----------------------------------------------------------------
`define SPF_IDX_HYS0     4'h6
`define SPF_IDX_HYS1     4'h7
`define SPF_IDX_LOCK     4'h8
`define SPF_IDX_PARITY   4'h9
`define SPF_LOCK_ADDR    3'h4

// -----------------------------------------------------------------
// Key mid-pulse counts
// -----------------------------------------------------------------
`define SPF_KEY_PARITY   4'h1
`define SPF_KEY_HYST     4'h3
`define SPF_KEY_DOWN     4'h4
`define SPF_KEY_CHK_LO   4'h7
`define SPF_KEY_CHK_HI   4'h8
`define SPF_KEY_BITW     4'h9
`define SPF_KEY_MODE     4'hB
`define SPF_CNT_MAX      4'hF

// -----------------------------------------------------------------
// Try entry and limit codes
// -----------------------------------------------------------------
`define SPF_OP_ENTRY     6'h01
`define SPF_OP_DOWN_ENT  6'h3F
`define SPF_OP_MIN       6'h00
`define SPF_BITW_TOP     6'h20
`define SPF_HYS_ENTRY    2'h1
`define SPF_ADDR_ENTRY   8'h01

// -----------------------------------------------------------------
// Register map
// -----------------------------------------------------------------
`define SPF_OFS_CTRL     8'h00
`define SPF_OFS_STATUS   8'h04
`define SPF_OFS_CODES    8'h08
`define SPF_CTRL_RST     2'h1
`define SPF_CTRL_EN_BIT  0
`define SPF_CTRL_CLR_BIT 1

`endif

// ===== logic/spf_pkg.sv
// Purpose: Types of the supply-pulse fuse programmer
// Assumes: spf_defs.svh holds the numbers
// Notes:   Shared by the top and the fuse bank
`include "spf_defs.svh"

package spf_pkg;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_H1,
		ST_HM,
		ST_HH,
		ST_TRY,
		ST_BLOW_ADDR,
		ST_DONE
	} spf_state_e;

	typedef enum logic [2:0] {
		SEL_NONE,
		SEL_UP,
		SEL_DOWN,
		SEL_BITW,
		SEL_HYST,
		SEL_PARITY
	} spf_try_e;

	typedef enum logic [1:0] {
		TGT_BOP,
		TGT_HYSLOCK,
		TGT_PARITY
	} spf_tgt_e;

	typedef struct packed {
		logic                  parity;
		logic                  lock;
		logic [`SPF_HYS_W-1:0] hyst;
		logic [`SPF_OP_W-1:0]  operate_point_code;
	} spf_fuse_s;

	typedef struct packed {
		logic                  fire;
		logic [`SPF_IDX_W-1:0] idx;
	} spf_blow_s;

endpackage

// ===== logic/spf_fuse_bank.sv
// Purpose: Fuse storage; one addressed fuse blown per fire strobe
// Assumes: Reset models a blank part
// Notes:   Blown bits return to zero only at reset
`timescale 1ns/1ps
`default_nettype none
`include "spf_defs.svh"

module spf_fuse_bank
	import spf_pkg::*;
(
	// Clock and reset
	input  wire logic      i_ref_clk,
	input  wire logic      i_rst,
	// Blow request
	input  wire spf_blow_s i_blow,
	// Fuse state
	output spf_fuse_s      o_fuse
);

	// -----------------------------------------------------------------
	// Per-fuse next state
	// -----------------------------------------------------------------
	logic [`SPF_FUSE_N-1:0] fuse;
	logic [`SPF_FUSE_N-1:0] next_fuse;

	genvar gi;
	generate
		for (gi = 0; gi < `SPF_FUSE_N; gi++) begin : g_fuse
			localparam int FUSE_IDX = gi;
			always_comb begin
				next_fuse[gi] = fuse[gi] |
					(i_blow.fire && (i_blow.idx == FUSE_IDX[`SPF_IDX_W-1:0]));
			end
		end
	endgenerate

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			fuse <= '0;
		end else begin
			fuse <= next_fuse;
		end
	end

	assign o_fuse = spf_fuse_s'(fuse);

endmodule
`default_nettype wire

// ===== logic/spf_fuse_prog.sv
// Purpose: Supply-pulse key decoder, Try counters, fuse blow and AHB-Lite
// Assumes: Pulse symbols are one-cycle strobes at each pulse falling edge
// Notes:   Registers: CTRL 0x00, STATUS 0x04, CODES 0x08
//
// Function
// - Lock fuse blown refuses further operate-point and hysteresis blows.
// - Fuse checks work only from the hysteresis Try key, before and after lock.
// - High-threshold check tests blown fuses; key high, 3 mid, high, 8 mid.
// - Low-threshold check tests intact fuses; key high, 3 mid, high, 7 mid.
// - Any marginal fuse during a check raises the current step output.
// - Each Try mid pulse after a selection key advances the selected code.
// - Up register loads 1, increments per pulse, wraps 63 to 0.
// - Down register loads 63, decrements per pulse, wraps.
// - Bitwise register walks one-hot 000001 to 100000, starting at bit 0.
// - Blow key adds eleven mids and high; n mids address; high blows.
// - Operate-point fuse field is 6 bits, unblown code 0.
// - Hysteresis field is 2 bits, Try entry loads code 1.
// - Parity blow decides by itself, needing no address pulses.
// - Try codes step once at each mid pulse falling edge.
// - Blow address is a one-hot shift from bit 0, one fuse only.
// - Supply power-up clears all Try settings.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "spf_defs.svh"

module spf_fuse_prog
	import spf_pkg::*;
(
	// Clock and reset
	input  wire logic                   i_ref_clk,
	input  wire logic                   i_rst,
	// AHB-Lite slave
	input  wire logic                   i_hsel,
	input  wire logic [31:0]            i_haddr,
	input  wire logic [1:0]             i_htrans,
	input  wire logic                   i_hwrite,
	input  wire logic [2:0]             i_hsize,
	input  wire logic [31:0]            i_hwdata,
	input  wire logic                   i_hready,
	output logic      [31:0]            o_hrdata,
	output logic                        o_hreadyout,
	output logic                        o_hresp,
	// Classified supply pulses
	input  wire logic                   i_mid_level_pulse,
	input  wire logic                   i_high_level_pulse,
	input  wire logic                   i_supply_power_up,
	// Fuse sense
	input  wire logic [`SPF_FUSE_N-1:0] i_weak_blown,
	input  wire logic [`SPF_FUSE_N-1:0] i_weak_intact,
	// Trim and programming outputs
	output logic [`SPF_OP_W-1:0]        o_operate_point_code,
	output logic [`SPF_HYS_W-1:0]       o_hysteresis_code,
	output logic                        o_supply_current_step,
	output logic                        o_fuse_blow_pulse,
	output logic [`SPF_IDX_W-1:0]       o_fuse_blow_index,
	output logic                        o_locked
);

	// -----------------------------------------------------------------
	// Declarations
	// -----------------------------------------------------------------
	spf_state_e              state;
	spf_state_e              next_state;
	spf_try_e                sel;
	spf_try_e                next_sel;
	spf_tgt_e                tgt;
	spf_tgt_e                next_tgt;
	logic [`SPF_CNT_W-1:0]   mid_cnt;
	logic [`SPF_CNT_W-1:0]   next_mid_cnt;
	logic [`SPF_OP_W-1:0]    op_try;
	logic [`SPF_OP_W-1:0]    next_op_try;
	logic [`SPF_HYS_W-1:0]   hys_try;
	logic [`SPF_HYS_W-1:0]   next_hys_try;
	logic                    par_try;
	logic                    next_par_try;
	logic [`SPF_ADDR_W-1:0]  addr;
	logic [`SPF_ADDR_W-1:0]  next_addr;
	spf_blow_s               blow;
	spf_blow_s               next_blow;
	logic                    refused;
	logic                    next_refused;
	spf_fuse_s               fuse;
	logic [`SPF_FUSE_N-1:0]  fuse_vec;
	logic [`SPF_CNT_W-1:0]   cnt_inc;
	logic [2:0]              addr_pos;
	logic                    addr_hit;
	logic                    chk_lo;
	logic                    chk_hi;
	logic                    try_op;
	logic [`SPF_OP_W-1:0]    op_eff;
	logic [`SPF_HYS_W-1:0]   hys_eff;
	logic                    margin;
	logic [1:0]              ctrl;
	logic [1:0]              next_ctrl;
	logic                    wr_pend;
	logic                    next_wr_pend;
	logic [7:0]              wr_addr;
	logic [7:0]              next_wr_addr;
	logic [31:0]             rd_mux;
	logic                    ahb_go;
	logic                    prog_en;
	logic                    clr_refused;

	assign fuse_vec = fuse;
	assign prog_en  = ctrl[`SPF_CTRL_EN_BIT];
	assign cnt_inc  = (mid_cnt == `SPF_CNT_MAX) ? mid_cnt : mid_cnt + 4'h1;

	// -----------------------------------------------------------------
	// Fuse storage
	// -----------------------------------------------------------------
	spf_fuse_bank u_fuse_bank (
		.i_ref_clk (i_ref_clk),
		.i_rst     (i_rst),
		.i_blow    (blow),
		.o_fuse    (fuse)
	);

	// -----------------------------------------------------------------
	// Address decode and fuse checks
	// -----------------------------------------------------------------
	always_comb begin
		addr_pos = 3'h0;
		addr_hit = 1'b0;
		for (int i = 0; i < `SPF_ADDR_W; i++) begin
			if (addr[i]) begin
				addr_pos = i[2:0];
				addr_hit = 1'b1;
			end
		end
	end

	assign chk_lo = (state == ST_TRY) && (sel == SEL_HYST) &&
		(mid_cnt == `SPF_KEY_CHK_LO);
	assign chk_hi = (state == ST_TRY) && (sel == SEL_HYST) &&
		(mid_cnt == `SPF_KEY_CHK_HI);
	assign margin = (chk_hi && |(fuse_vec & i_weak_blown)) ||
		(chk_lo && |(~fuse_vec & i_weak_intact));

	assign try_op  = (sel == SEL_UP) || (sel == SEL_DOWN) || (sel == SEL_BITW);
	assign op_eff  = try_op ? op_try : fuse.operate_point_code;
	assign hys_eff = (sel == SEL_HYST) ? hys_try : fuse.hyst;

	// -----------------------------------------------------------------
	// Key decoder and Try counters
	// -----------------------------------------------------------------
	always_comb begin
		next_state   = state;
		next_sel     = sel;
		next_tgt     = tgt;
		next_mid_cnt = mid_cnt;
		next_op_try  = op_try;
		next_hys_try = hys_try;
		next_par_try = par_try;
		next_addr    = addr;
		next_blow    = '0;
		next_refused = refused | 1'b0;
		if (i_supply_power_up) begin
			next_state   = ST_IDLE;
			next_sel     = SEL_NONE;
			next_mid_cnt = '0;
			next_op_try  = `SPF_OP_MIN;
			next_hys_try = '0;
			next_par_try = 1'b0;
			next_addr    = '0;
		end else if (prog_en && i_mid_level_pulse) begin
			unique case (state)
				ST_IDLE: begin
					next_state = ST_IDLE;
				end
				ST_H1: begin
					next_state   = ST_HM;
					next_mid_cnt = 4'h1;
				end
				ST_HM: begin
					next_mid_cnt = cnt_inc;
				end
				ST_HH: begin
					next_mid_cnt = cnt_inc;
					next_op_try  = op_try + 6'h01;
				end
				ST_TRY: begin
					next_mid_cnt = cnt_inc;
					unique case (sel)
						SEL_DOWN: next_op_try = op_try - 6'h01;
						SEL_BITW: begin
							if (op_try == `SPF_BITW_TOP) begin
								next_op_try = `SPF_OP_MIN;
							end else if (op_try == `SPF_OP_MIN) begin
								next_op_try = `SPF_OP_ENTRY;
							end else begin
								next_op_try = op_try << 1;
							end
						end
						SEL_HYST:   next_hys_try = hys_try + 2'h1;
						SEL_PARITY: next_par_try = ~par_try;
						default:    next_op_try = op_try;
					endcase
				end
				ST_BLOW_ADDR: begin
					next_addr = addr << 1;
				end
				ST_DONE: begin
					next_state = ST_DONE;
				end
			endcase
		end else if (prog_en && i_high_level_pulse) begin
			next_mid_cnt = '0;
			unique case (state)
				ST_IDLE: begin
					next_state = ST_H1;
				end
				ST_H1: begin
					next_state  = ST_HH;
					next_sel    = SEL_UP;
					next_op_try = `SPF_OP_ENTRY;
				end
				ST_HM: begin
					if (mid_cnt == `SPF_KEY_PARITY) begin
						next_state   = ST_TRY;
						next_sel     = SEL_PARITY;
						next_par_try = 1'b1;
					end else if (mid_cnt == `SPF_KEY_HYST) begin
						next_state   = ST_TRY;
						next_sel     = SEL_HYST;
						next_hys_try = `SPF_HYS_ENTRY;
					end else begin
						next_state = ST_IDLE;
					end
				end
				ST_HH: begin
					if (mid_cnt == `SPF_KEY_DOWN) begin
						next_state  = ST_TRY;
						next_sel    = SEL_DOWN;
						next_op_try = `SPF_OP_DOWN_ENT;
					end else if (mid_cnt == `SPF_KEY_BITW) begin
						next_state  = ST_TRY;
						next_sel    = SEL_BITW;
						next_op_try = `SPF_OP_ENTRY;
					end else if (mid_cnt == `SPF_KEY_MODE) begin
						next_state = ST_BLOW_ADDR;
						next_sel   = SEL_NONE;
						next_tgt   = TGT_BOP;
						next_addr  = `SPF_ADDR_ENTRY;
					end else begin
						next_state = ST_IDLE;
						next_sel   = SEL_NONE;
					end
				end
				ST_TRY: begin
					next_sel = SEL_NONE;
					if (mid_cnt == `SPF_KEY_MODE &&
						(sel == SEL_HYST || sel == SEL_PARITY)) begin
						next_state = ST_BLOW_ADDR;
						next_tgt   = (sel == SEL_HYST) ? TGT_HYSLOCK : TGT_PARITY;
						next_addr  = `SPF_ADDR_ENTRY;
					end else begin
						next_state = ST_IDLE;
					end
				end
				ST_BLOW_ADDR: begin
					next_state = ST_DONE;
					unique case (tgt)
						TGT_BOP: begin
							if (fuse.lock) begin
								next_refused = 1'b1;
							end else begin
								next_blow.fire = addr_hit &&
									(addr_pos < 3'(`SPF_OP_W));
								next_blow.idx  = {1'b0, addr_pos};
							end
						end
						TGT_HYSLOCK: begin
							if (fuse.lock) begin
								next_refused = 1'b1;
							end else if (addr_hit && addr_pos == `SPF_LOCK_ADDR) begin
								next_blow.fire = 1'b1;
								next_blow.idx  = `SPF_IDX_LOCK;
							end else if (addr_hit && addr_pos < 3'(`SPF_HYS_W)) begin
								next_blow.fire = 1'b1;
								next_blow.idx  = addr_pos[0] ? `SPF_IDX_HYS1 : `SPF_IDX_HYS0;
							end
						end
						TGT_PARITY: begin
							next_blow.fire = !fuse.parity &&
								(^{fuse.lock, fuse.hyst, fuse.operate_point_code});
							next_blow.idx  = `SPF_IDX_PARITY;
						end
						default: next_blow = '0;
					endcase
				end
				ST_DONE: begin
					next_state = ST_DONE;
				end
			endcase
		end
		if (clr_refused && next_refused == refused) begin
			next_refused = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state   <= ST_IDLE;
			sel     <= SEL_NONE;
			tgt     <= TGT_BOP;
			mid_cnt <= '0;
			op_try  <= `SPF_OP_MIN;
			hys_try <= '0;
			par_try <= 1'b0;
			addr    <= '0;
			blow    <= '0;
			refused <= 1'b0;
		end else begin
			state   <= next_state;
			sel     <= next_sel;
			tgt     <= next_tgt;
			mid_cnt <= next_mid_cnt;
			op_try  <= next_op_try;
			hys_try <= next_hys_try;
			par_try <= next_par_try;
			addr    <= next_addr;
			blow    <= next_blow;
			refused <= next_refused;
		end
	end

	// -----------------------------------------------------------------
	// AHB-Lite slave
	// -----------------------------------------------------------------
	assign ahb_go      = i_hsel && i_htrans[1] && i_hready;
	assign clr_refused = wr_pend && (wr_addr == `SPF_OFS_CTRL) &&
		i_hwdata[`SPF_CTRL_CLR_BIT];

	always_comb begin
		next_wr_pend = ahb_go && i_hwrite && (i_hsize == 3'h2);
		next_wr_addr = ahb_go ? i_haddr[7:0] : wr_addr;
		next_ctrl    = ctrl;
		if (wr_pend && wr_addr == `SPF_OFS_CTRL) begin
			next_ctrl = {1'b0, i_hwdata[`SPF_CTRL_EN_BIT]};
		end
		rd_mux = 32'h00000000;
		unique case (i_haddr[7:0])
			`SPF_OFS_CTRL:   rd_mux = {30'h0, ctrl};
			`SPF_OFS_STATUS: rd_mux = {22'h0, margin, refused, fuse.lock,
				sel, 1'b0, state};
			`SPF_OFS_CODES:  rd_mux = {6'h0, fuse_vec, 6'h0, hys_eff,
				2'h0, op_eff};
			default:         rd_mux = 32'h00000000;
		endcase
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			ctrl        <= `SPF_CTRL_RST;
			wr_pend     <= 1'b0;
			wr_addr     <= 8'h00;
			o_hrdata    <= 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			ctrl        <= next_ctrl;
			wr_pend     <= next_wr_pend;
			wr_addr     <= next_wr_addr;
			o_hrdata    <= (ahb_go && !i_hwrite) ? rd_mux : 32'h00000000;
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end
	end

	// -----------------------------------------------------------------
	// Registered outputs
	// -----------------------------------------------------------------
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_operate_point_code  <= '0;
			o_hysteresis_code     <= '0;
			o_supply_current_step <= 1'b0;
			o_fuse_blow_pulse     <= 1'b0;
			o_fuse_blow_index     <= '0;
			o_locked              <= 1'b0;
		end else begin
			o_operate_point_code  <= op_eff;
			o_hysteresis_code     <= hys_eff;
			o_supply_current_step <= margin;
			o_fuse_blow_pulse     <= next_blow.fire;
			o_fuse_blow_index     <= next_blow.idx;
			o_locked              <= fuse.lock;
		end
	end

endmodule
`default_nettype wire

// ===== test/spf_fuse_prog_checker.sv
// Purpose: Port assertions of the fuse programmer
// Assumes: One clock domain, synchronous reset
// Notes:   Bound into spf_fuse_prog at the foot
`timescale 1ns/1ps
`default_nettype none
`include "spf_defs.svh"

module spf_fuse_prog_checker (
	// Clock and reset
	input wire logic                   i_ref_clk,
	input wire logic                   i_rst,
	// Pulses and sense
	input wire logic                   i_mid_level_pulse,
	input wire logic                   i_high_level_pulse,
	input wire logic                   i_supply_power_up,
	input wire logic [`SPF_FUSE_N-1:0] i_weak_blown,
	input wire logic [`SPF_FUSE_N-1:0] i_weak_intact,
	// Watched outputs
	input wire logic [`SPF_OP_W-1:0]   o_operate_point_code,
	input wire logic [`SPF_HYS_W-1:0]  o_hysteresis_code,
	input wire logic                   o_supply_current_step,
	input wire logic                   o_fuse_blow_pulse,
	input wire logic [`SPF_IDX_W-1:0]  o_fuse_blow_index,
	input wire logic                   o_locked
);
	logic any_strobe;
	logic no_margin;

	assign any_strobe = i_mid_level_pulse | i_high_level_pulse | i_supply_power_up;
	assign no_margin  = !(|i_weak_blown) && !(|i_weak_intact);

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	// ---------------------------------------------------------
	// Sequences
	// ---------------------------------------------------------
	sequence s_lock_fire;
		o_fuse_blow_pulse && o_fuse_blow_index == `SPF_IDX_LOCK && !o_locked;
	endsequence
	sequence s_clean;
		no_margin [*2];
	endsequence

	// ---------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------
	a_blow_one_cycle: assert property (o_fuse_blow_pulse |=> !o_fuse_blow_pulse)
		else $error("blow pulse longer than one cycle");
	a_blow_from_high: assert property (o_fuse_blow_pulse |-> $past(i_high_level_pulse))
		else $error("blow pulse without a high pulse");
	a_blow_index_max: assert property (o_fuse_blow_pulse |-> o_fuse_blow_index <= 4'h9)
		else $error("blow index outside the fuse vector");
	a_locked_no_trim: assert property (o_locked && o_fuse_blow_pulse |->
		o_fuse_blow_index == `SPF_IDX_PARITY)
		else $error("trim fuse blown while locked");
	a_lock_follows: assert property (s_lock_fire |-> ##2 o_locked)
		else $error("lock fuse blown but part not locked");
	a_lock_sticky: assert property (o_locked |=> o_locked)
		else $error("lock dropped");
	a_no_margin_step: assert property (s_clean |=> !o_supply_current_step)
		else $error("current step without marginal fuse");
	a_code_cause: assert property ($changed({o_operate_point_code, o_hysteresis_code}) |->
		$past(any_strobe, 2) || $past(any_strobe, 3))
		else $error("code changed without a pulse");
endmodule

bind spf_fuse_prog spf_fuse_prog_checker chk_u (
	.i_ref_clk            (i_ref_clk),
	.i_rst                (i_rst),
	.i_mid_level_pulse    (i_mid_level_pulse),
	.i_high_level_pulse   (i_high_level_pulse),
	.i_supply_power_up    (i_supply_power_up),
	.i_weak_blown         (i_weak_blown),
	.i_weak_intact        (i_weak_intact),
	.o_operate_point_code (o_operate_point_code),
	.o_hysteresis_code    (o_hysteresis_code),
	.o_supply_current_step(o_supply_current_step),
	.o_fuse_blow_pulse    (o_fuse_blow_pulse),
	.o_fuse_blow_index    (o_fuse_blow_index),
	.o_locked             (o_locked)
);
`default_nettype wire

// ===== test/spf_prog_model.sv
// Purpose: External programmer sending classified supply pulses
// Assumes: Pulses reach the block as one-cycle strobes
// Notes:   Driven through its tasks from the testbench
`timescale 1ns/1ps
`default_nettype none

module spf_prog_model #(
	parameter int POST_BLOW_CYC = 8
) (
	input  wire logic i_ref_clk,
	output logic      o_mid_level_pulse,
	output logic      o_high_level_pulse,
	output logic      o_supply_power_up
);
	initial begin
		o_mid_level_pulse  = 1'b0;
		o_high_level_pulse = 1'b0;
		o_supply_power_up  = 1'b0;
	end

	task automatic strobe(input logic hi);
		@(posedge i_ref_clk);
		if (hi) begin
			o_high_level_pulse <= 1'b1;
		end else begin
			o_mid_level_pulse <= 1'b1;
		end
		@(posedge i_ref_clk);
		o_high_level_pulse <= 1'b0;
		o_mid_level_pulse  <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask

	task automatic send(input string s);
		for (int k = 0; k < s.len(); k++) begin
			strobe(s[k] == 8'h48);
		end
	endtask

	task automatic mids(input int n);
		repeat (n) strobe(1'b0);
	endtask

	// Blow pulse, then wait before power-down
	task automatic blow();
		strobe(1'b1);
		repeat (POST_BLOW_CYC) @(posedge i_ref_clk);
	endtask

	// Power cycle between fuses
	task automatic power_cycle();
		@(posedge i_ref_clk);
		o_supply_power_up <= 1'b1;
		@(posedge i_ref_clk);
		o_supply_power_up <= 1'b0;
		repeat (3) @(posedge i_ref_clk);
	endtask

	// Hysteresis key, blow key, bit 4, blow
	task automatic lock_part();
		send("HMMMH");
		mids(11);
		send("H");
		mids(4);
		blow();
	endtask
endmodule
`default_nettype wire

// ===== test/tb.sv
// Purpose: Self-checking bench of the fuse programmer
// Assumes: Zero-wait AHB-Lite slave, blank fuses after reset
// Notes:   Pulses come from spf_prog_model
`timescale 1ns/1ps
`default_nettype none
`include "spf_defs.svh"

module tb;
	logic                   ref_clk;
	logic                   rst;
	logic                   hsel;
	logic [31:0]            haddr;
	logic [1:0]             htrans;
	logic                   hwrite;
	logic [2:0]             hsize;
	logic [31:0]            hwdata;
	logic [31:0]            hrdata;
	logic                   hreadyout;
	logic                   hresp;
	logic                   mid;
	logic                   high;
	logic                   pwr;
	logic [`SPF_FUSE_N-1:0] weak_blown;
	logic [`SPF_FUSE_N-1:0] weak_intact;
	logic [`SPF_OP_W-1:0]   op_code;
	logic [`SPF_HYS_W-1:0]  hys_code;
	logic                   cur_step;
	logic                   blow_pulse;
	logic [`SPF_IDX_W-1:0]  blow_idx;
	logic                   locked;
	logic [31:0]            q;
	int                     bad_count;
	int                     n_compared;
	int                     n_fire = 0;
	logic [`SPF_IDX_W-1:0]  fire_idx;

	spf_fuse_prog dut_u (
		.i_ref_clk(ref_clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
		.i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata),
		.i_hready(hreadyout), .o_hrdata(hrdata), .o_hreadyout(hreadyout), .o_hresp(hresp),
		.i_mid_level_pulse(mid), .i_high_level_pulse(high), .i_supply_power_up(pwr),
		.i_weak_blown(weak_blown), .i_weak_intact(weak_intact),
		.o_operate_point_code(op_code), .o_hysteresis_code(hys_code),
		.o_supply_current_step(cur_step), .o_fuse_blow_pulse(blow_pulse),
		.o_fuse_blow_index(blow_idx), .o_locked(locked)
	);

	spf_prog_model prog_u (
		.i_ref_clk(ref_clk), .o_mid_level_pulse(mid),
		.o_high_level_pulse(high), .o_supply_power_up(pwr)
	);

	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	always @(posedge ref_clk) begin
		if (blow_pulse === 1'b1) begin
			n_fire   <= n_fire + 1;
			fire_idx <= blow_idx;
		end
	end

	// ---------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel   <= 1'b1;
		haddr  <= {24'h0, a};
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge ref_clk); while (hreadyout !== 1'b1);
		q = hrdata;
	endtask

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ---------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------
	task automatic t_regs();
		ahb(1'b0, `SPF_OFS_CTRL, 32'h0);
		check(q, 32'h1);
		check(32'(hresp), 32'h0);
		ahb(1'b0, `SPF_OFS_STATUS, 32'h0);
		check(q, 32'h0);
		ahb(1'b0, 8'h0C, 32'h0);
		check(q, 32'h0);
		ahb(1'b1, `SPF_OFS_CTRL, 32'h0);
		prog_u.send("HH");
		check(32'(op_code), 32'h0);
		ahb(1'b1, `SPF_OFS_CTRL, 32'h1);
		$display("t_regs done");
	endtask

	task automatic t_up();
		prog_u.power_cycle();
		prog_u.send("HH");
		check(32'(op_code), 32'h1);
		ahb(1'b0, `SPF_OFS_CODES, 32'h0);
		check(q, 32'h1);
		prog_u.mids(62);
		check(32'(op_code), 32'h3F);
		prog_u.mids(1);
		check(32'(op_code), 32'h0);
		$display("t_up done");
	endtask

	task automatic t_down_bitw();
		prog_u.power_cycle();
		prog_u.send("HHMMMMH");
		check(32'(op_code), 32'h3F);
		prog_u.mids(1);
		check(32'(op_code), 32'h3E);
		prog_u.power_cycle();
		prog_u.send("HHMMMMMMMMMH");
		check(32'(op_code), 32'h1);
		prog_u.mids(5);
		check(32'(op_code), 32'h20);
		$display("t_down_bitw done");
	endtask

	task automatic t_hyst();
		prog_u.power_cycle();
		prog_u.send("HMMMH");
		check(32'(hys_code), 32'h1);
		prog_u.mids(2);
		check(32'(hys_code), 32'h3);
		prog_u.power_cycle();
		check(32'(hys_code), 32'h0);
		prog_u.send("HMMH");
		ahb(1'b0, `SPF_OFS_STATUS, 32'h0);
		check(q & 32'h77, 32'h0);
		$display("t_hyst done");
	endtask

	task automatic t_blow();
		int n0;
		prog_u.power_cycle();
		prog_u.send("HH");
		prog_u.mids(11);
		prog_u.send("H");
		prog_u.mids(3);
		n0 = n_fire;
		prog_u.blow();
		check(n_fire - n0, 1);
		check(32'(fire_idx), 32'h3);
		prog_u.send("HH");
		check(32'(op_code), 32'h8);
		prog_u.power_cycle();
		prog_u.send("HMH");
		prog_u.mids(11);
		prog_u.send("H");
		n0 = n_fire;
		prog_u.blow();
		check(n_fire - n0, 1);
		check(32'(fire_idx), 32'h9);
		prog_u.power_cycle();
		prog_u.send("HMMMH");
		prog_u.mids(11);
		prog_u.send("H");
		prog_u.mids(1);
		n0 = n_fire;
		prog_u.blow();
		check(n_fire - n0, 1);
		check(32'(fire_idx), 32'h7);
		prog_u.power_cycle();
		check(32'(hys_code), 32'h2);
		$display("t_blow done");
	endtask

	task automatic t_check();
		prog_u.power_cycle();
		weak_intact <= 10'h001;
		prog_u.send("HMMMH");
		check(32'(cur_step), 32'h0);
		prog_u.mids(7);
		check(32'(cur_step), 32'h1);
		prog_u.mids(1);
		check(32'(cur_step), 32'h0);
		weak_blown <= 10'h001;
		repeat (3) @(posedge ref_clk);
		check(32'(cur_step), 32'h0);
		weak_blown <= 10'h008;
		repeat (3) @(posedge ref_clk);
		check(32'(cur_step), 32'h1);
		weak_blown  <= 10'h000;
		weak_intact <= 10'h000;
		$display("t_check done");
	endtask

	task automatic t_lock();
		int n0;
		prog_u.power_cycle();
		prog_u.lock_part();
		check(32'(fire_idx), 32'h8);
		check(32'(locked), 32'h1);
		prog_u.power_cycle();
		prog_u.send("HH");
		prog_u.mids(11);
		prog_u.send("H");
		n0 = n_fire;
		prog_u.blow();
		check(n_fire - n0, 0);
		ahb(1'b0, `SPF_OFS_STATUS, 32'h0);
		check(q & 32'h180, 32'h180);
		ahb(1'b1, `SPF_OFS_CTRL, 32'h3);
		ahb(1'b0, `SPF_OFS_STATUS, 32'h0);
		check(q & 32'h100, 32'h0);
		$display("t_lock done");
	endtask

	initial begin
		#2000000;
		bad_count++;
		wrap_up();
	end

	initial begin
		rst         = 1'b1;
		hsel        = 1'b0;
		haddr       = 32'h0;
		htrans      = 2'h0;
		hwrite      = 1'b0;
		hsize       = 3'h2;
		hwdata      = 32'h0;
		weak_blown  = 10'h000;
		weak_intact = 10'h000;
		bad_count   = 0;
		n_compared  = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs();
		t_up();
		t_down_bitw();
		t_hyst();
		t_blow();
		t_check();
		t_lock();
		t_check();
		wrap_up();
	end
endmodule
`default_nettype wire
